// ===== hw/rls_pkg.sv
package rls_pkg;

  // Register byte offsets, one aligned word each
  localparam logic [7:0]  RLS_OFS_CTRL     = 8'h00;
  localparam logic [7:0]  RLS_OFS_COUNT    = 8'h04;
  localparam logic [7:0]  RLS_OFS_STATUS   = 8'h08;

  // Control word field positions
  localparam int          RLS_CTRL_SEL_LSB = 0;
  localparam int          RLS_CTRL_SEL_W   = 4;
  localparam int          RLS_CTRL_FBA_BIT = 4;
  localparam int          RLS_CTRL_D2E_BIT = 5;
  localparam int          RLS_CTRL_CRL_BIT = 6;
  localparam int          RLS_CTRL_GO_BIT  = 8;

  // Status word field positions
  localparam int          RLS_STAT_BUSY    = 0;
  localparam int          RLS_STAT_DONE    = 1;
  localparam int          RLS_STAT_ST_LSB  = 2;

  // Count field width
  localparam int          RLS_COUNT_W      = 21;

  // Reset values
  localparam logic [3:0]  RLS_SEL_RST      = 4'h1;
  localparam logic [20:0] RLS_COUNT_RST    = 21'h100000;

  // Sync source selector codes; every other code is reserved
  localparam logic [3:0]  RLS_SRC_ALIGN    = 4'h1;
  localparam logic [3:0]  RLS_SRC_LOOP0    = 4'h2;
  localparam logic [3:0]  RLS_SRC_D2       = 4'h4;
  localparam logic [3:0]  RLS_SRC_LOOP1    = 4'h8;

  // Positions of the external sources in the synchroniser vector
  localparam int          RLS_IDX_ALIGN    = 0;
  localparam int          RLS_IDX_LOOP0    = 1;
  localparam int          RLS_IDX_D2       = 2;
  localparam int          RLS_IDX_LOOP1    = 3;
  localparam int          RLS_NUM_SRC      = 4;

  // Sequencer states
  typedef enum logic [1:0] {
    RLS_ST_IDLE,
    RLS_ST_ARM,
    RLS_ST_HOLD
  } rls_state_type;

endpackage

// ===== hw/rls_sync2.sv
`timescale 1ns/1ns
// Two-flop synchroniser, one lane per bit
module rls_sync2 #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  genvar i;

  // Each lane: the first flop feeds only the second
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic meta_r;  // Metastable stage, read by q only
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          meta_r <= 1'b0;
          q[i]   <= 1'b0;
        end else begin
          meta_r <= d[i];
          q[i]   <= meta_r;
        end
      end
    end
  endgenerate

endmodule

// ===== hw/rls_release_counter.sv
`timescale 1ns/1ns
// Down counter that ends the divider hold after a programmed count
module rls_release_counter
  import rls_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   load,
  input  wire logic [RLS_COUNT_W-1:0] count_value,
  output logic                        done_r
);

  logic [RLS_COUNT_W-1:0] count_r;    // Cycles left
  logic                   running_r;  // Count in progress

  // Load, count down, pulse done on the last cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_r   <= '0;
      running_r <= 1'b0;
      done_r    <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (load) begin
        // Zero is outside the usable range; treat it as one
        count_r   <= (count_value == '0) ? RLS_COUNT_W'(1) : count_value;
        running_r <= 1'b1;
      end else if (running_r) begin
        if (count_r == RLS_COUNT_W'(1)) begin
          running_r <= 1'b0;
          done_r    <= 1'b1;
        end else begin
          count_r <= count_r - RLS_COUNT_W'(1);
        end
      end
    end
  end

endmodule

// ===== hw/rls_top.sv
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ns
// Operation
// [R1] Code 0001 picks alignment pulse; 0000 reserved
// [R2] Code 0010 picks first loop feedback divider
// [R3] Code 0100 picks digital output two
// [R4] Code 1000 picks second loop feedback divider
// [R5] Software sets selector before divider reset
// [R6] Software sets feedback choice before divider reset
// [R7] Choice 0: feedback from VCO before sync
// [R8] Choice 1: feedback from VCO after sync
// [R9] D2 clock low unless trigger enabled
// [R10] Release by second loop or count end
// [R11] 21-bit count, reset 0x100000, range 1..2097151
// [R12] Reserved selector codes produce no sync event
module rls_top
  import rls_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        internal_alignment_pulse,
  input  wire logic        first_loop_fb_div,
  input  wire logic        second_loop_fb_div,
  input  wire logic        digital_output_two,
  output logic             rf_sync_event,
  output logic             rf_div_reset_hold,
  output logic             rf_feedback_clock_choice,
  output logic             d2_trigger_clk
);

  // Software-visible configuration
  logic [3:0]             rf_sync_source_sel_r;            // Source code
  logic                   rf_feedback_clock_after_sync_r;  // Feedback VCO tap
  logic                   d2_trigger_enable_r;             // D2 gate
  logic                   rf_sync_counter_release_r;       // Release mode
  logic [RLS_COUNT_W-1:0] rf_sync_count_value_r;           // Release count
  logic                   done_r;                          // Sticky completion

  // Bus handshake state
  logic                   pready_r;      // Access answered this cycle
  logic [31:0]            prdata_r;      // Read data
  logic                   pslverr_r;     // Unmapped address answer
  logic                   acc_go;        // Access takes effect now
  logic                   wr_ctrl;       // Write to control word
  logic                   wr_count;      // Write to count word
  logic                   wr_status;     // Write to status word
  logic                   addr_ok;       // Address is mapped

  // Source synchronisation and edges
  logic [RLS_NUM_SRC-1:0] src_raw;       // Pins from foreign domains
  logic [RLS_NUM_SRC-1:0] src_sync;      // After two flops
  logic [RLS_NUM_SRC-1:0] src_prev_r;    // One cycle older copy
  logic [RLS_NUM_SRC-1:0] src_rise;      // Rising edge per source

  // Sequencer
  rls_state_type          state_r;       // Current state
  rls_state_type          state_nxt;     // Next state
  logic                   start_req;     // Software asked for sync
  logic                   sel_edge;      // Edge of chosen source
  logic                   sel_valid;     // Chosen code is not reserved
  logic                   go_code_ok;    // Code written with go is defined
  logic                   fire;          // Sync event now
  logic                   release_now;   // End of divider hold
  logic                   cnt_done;      // Count completed
  logic                   sync_event_r;  // Output pulse
  logic                   div_hold_r;    // Divider held in reset
  logic                   fb_choice_r;   // Feedback clock select out
  logic                   d2_clk_r;      // Gated D2 clock out

  // Bus decode; one wait state, answer on the second access cycle
  assign acc_go    = psel & penable & pready_r;
  assign addr_ok   = (paddr == RLS_OFS_CTRL) | (paddr == RLS_OFS_COUNT) | (paddr == RLS_OFS_STATUS);
  assign wr_ctrl   = acc_go & pwrite & (paddr == RLS_OFS_CTRL);
  assign wr_count  = acc_go & pwrite & (paddr == RLS_OFS_COUNT);
  assign wr_status = acc_go & pwrite & (paddr == RLS_OFS_STATUS);

  // Ready rises one cycle into the access phase and falls after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= psel & penable & ~pready_r;
    end
  end

  // Error flag prepared with ready, for unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= psel & penable & ~pready_r & ~addr_ok;
    end
  end

  // Read data captured as ready rises, cleared only while psel is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (psel & penable & ~pready_r & ~pwrite) begin
      prdata_r <= '0;
      case (paddr)
        RLS_OFS_CTRL: begin
          prdata_r[RLS_CTRL_SEL_LSB +: RLS_CTRL_SEL_W] <= rf_sync_source_sel_r;
          prdata_r[RLS_CTRL_FBA_BIT]                   <= rf_feedback_clock_after_sync_r;
          prdata_r[RLS_CTRL_D2E_BIT]                   <= d2_trigger_enable_r;
          prdata_r[RLS_CTRL_CRL_BIT]                   <= rf_sync_counter_release_r;
          prdata_r[RLS_CTRL_GO_BIT]                    <= (state_r != RLS_ST_IDLE);
        end
        RLS_OFS_COUNT: begin
          prdata_r[RLS_COUNT_W-1:0] <= rf_sync_count_value_r;
        end
        RLS_OFS_STATUS: begin
          prdata_r[RLS_STAT_BUSY]          <= (state_r != RLS_ST_IDLE);
          prdata_r[RLS_STAT_DONE]          <= done_r;
          prdata_r[RLS_STAT_ST_LSB +: 2]   <= state_r;
        end
        default: begin
          // Unmapped reads return zero
          prdata_r <= '0;
        end
      endcase
    end else if (!psel) begin
      prdata_r <= '0;
    end
  end

  // Control word storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_sync_source_sel_r           <= RLS_SEL_RST;  // see [R1]
      rf_feedback_clock_after_sync_r <= 1'b0;
      d2_trigger_enable_r            <= 1'b0;
      rf_sync_counter_release_r      <= 1'b0;
    end else if (wr_ctrl) begin
      rf_sync_source_sel_r           <= pwdata[RLS_CTRL_SEL_LSB +: RLS_CTRL_SEL_W];
      rf_feedback_clock_after_sync_r <= pwdata[RLS_CTRL_FBA_BIT];
      d2_trigger_enable_r            <= pwdata[RLS_CTRL_D2E_BIT];
      rf_sync_counter_release_r      <= pwdata[RLS_CTRL_CRL_BIT];
    end
  end

  // Count storage, full 21-bit field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_sync_count_value_r <= RLS_COUNT_RST;  // see [R11]
    end else if (wr_count) begin
      rf_sync_count_value_r <= pwdata[RLS_COUNT_W-1:0];  // see [R11]
    end
  end

  // Sticky completion flag; a release in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
    end else if (release_now) begin
      done_r <= 1'b1;
    end else if (wr_status & pwdata[RLS_STAT_DONE]) begin
      done_r <= 1'b0;
    end
  end

  // The go bit in the same write as the selector uses the new code,
  // so one write can both configure and start
  assign start_req = wr_ctrl & pwdata[RLS_CTRL_GO_BIT];  // see [R5] [R6]

  // Judge the code in the go write itself; the stored code is still the old one
  assign go_code_ok = pwdata[RLS_CTRL_SEL_LSB +: RLS_CTRL_SEL_W] inside {RLS_SRC_ALIGN, RLS_SRC_LOOP0,
                                                                        RLS_SRC_D2, RLS_SRC_LOOP1};

  // All source pins come from other clock domains
  assign src_raw[RLS_IDX_ALIGN] = internal_alignment_pulse;
  assign src_raw[RLS_IDX_LOOP0] = first_loop_fb_div;
  assign src_raw[RLS_IDX_D2]    = digital_output_two;
  assign src_raw[RLS_IDX_LOOP1] = second_loop_fb_div;

  rls_sync2 #(
    .W    (RLS_NUM_SRC)
  ) u_sync (
    .clk  (pclk),
    .rstn (presetn),
    .d    (src_raw),
    .q    (src_sync)
  );

  // Edge history; sources slower than half pclk only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_r <= '0;
    end else begin
      src_prev_r <= src_sync;
    end
  end

  assign src_rise = src_sync & ~src_prev_r;

  // Source choice from the selector, decoded from the stored code
  always_comb begin
    sel_edge  = 1'b0;
    sel_valid = 1'b1;
    case (rf_sync_source_sel_r)
      RLS_SRC_ALIGN: sel_edge = src_rise[RLS_IDX_ALIGN];  // see [R1]
      RLS_SRC_LOOP0: sel_edge = src_rise[RLS_IDX_LOOP0];  // see [R2]
      RLS_SRC_D2:    sel_edge = src_rise[RLS_IDX_D2];     // see [R3]
      RLS_SRC_LOOP1: sel_edge = src_rise[RLS_IDX_LOOP1];  // see [R4]
      default: begin
        // Reserved codes never yield an edge
        sel_edge  = 1'b0;  // see [R12]
        sel_valid = 1'b0;  // see [R12]
      end
    endcase
  end

  // Sync fires on the first chosen edge while armed
  assign fire = (state_r == RLS_ST_ARM) & sel_edge;

  // Hold ends by second loop edge or by count completion
  assign release_now = (state_r == RLS_ST_HOLD) &
                       (rf_sync_counter_release_r ? cnt_done
                                                  : src_rise[RLS_IDX_LOOP1]);  // see [R10]

  rls_release_counter u_count (
    .clk         (pclk),
    .rstn        (presetn),
    .load        (fire & rf_sync_counter_release_r),  // see [R10]
    .count_value (rf_sync_count_value_r),             // see [R11]
    .done_r      (cnt_done)
  );

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RLS_ST_IDLE: begin
        // A start with a reserved code is dropped
        if (start_req & go_code_ok) begin  // see [R12]
          state_nxt = RLS_ST_ARM;
        end
      end
      RLS_ST_ARM: begin
        if (!sel_valid) begin
          // Code changed to reserved while armed: give up quietly
          state_nxt = RLS_ST_IDLE;  // see [R12]
        end else if (fire) begin
          state_nxt = RLS_ST_HOLD;
        end
      end
      RLS_ST_HOLD: begin
        if (release_now) begin
          state_nxt = RLS_ST_IDLE;
        end
      end
      default: begin
        state_nxt = RLS_ST_IDLE;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= RLS_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // One-cycle sync event toward the output dividers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_event_r <= 1'b0;
    end else begin
      sync_event_r <= fire;  // see [R1] [R2] [R3] [R4]
    end
  end

  // Divider hold level, from the sync event until release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_hold_r <= 1'b0;
    end else if (fire) begin
      div_hold_r <= 1'b1;
    end else if (release_now) begin
      div_hold_r <= 1'b0;  // see [R10]
    end
  end

  // Feedback VCO tap select for the external glitch-free clock mux;
  // changing it mid-hold is legal but can disturb the loop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_choice_r <= 1'b0;  // see [R7]
    end else begin
      fb_choice_r <= rf_feedback_clock_after_sync_r;  // see [R7] [R8]
    end
  end

  // Gated D2 clock; resampled at pclk, so only slow D2 rates pass cleanly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d2_clk_r <= 1'b0;
    end else begin
      d2_clk_r <= d2_trigger_enable_r & src_sync[RLS_IDX_D2];  // see [R9]
    end
  end

  // All outputs straight from flops
  assign prdata                   = prdata_r;
  assign pready                   = pready_r;
  assign pslverr                  = pslverr_r;
  assign rf_sync_event            = sync_event_r;
  assign rf_div_reset_hold        = div_hold_r;
  assign rf_feedback_clock_choice = fb_choice_r;
  assign d2_trigger_clk           = d2_clk_r;

endmodule

// ===== test/rls_top_checker.sv
`timescale 1ns/1ns
// Watches bus timing and sync outputs at the block's pins
module rls_top_checker
  import rls_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        internal_alignment_pulse,
  input wire logic        first_loop_fb_div,
  input wire logic        second_loop_fb_div,
  input wire logic        digital_output_two,
  input wire logic        rf_sync_event,
  input wire logic        rf_div_reset_hold,
  input wire logic        rf_feedback_clock_choice,
  input wire logic        d2_trigger_clk
);
  logic [3:0]  sel_r;   // Shadow selector
  logic        crl_r;   // Shadow release mode
  logic [21:0] cnt_r;   // Shadow count, zero taken as one
  logic [7:0]  src_r;   // History of chosen source
  logic [7:0]  rel_r;   // History of release pin
  logic [21:0] len_r;   // Cycles the hold has stood
  logic        src;     // Chosen pin, dead for reserved codes
  logic        wr_ctrl; // Completed control write
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign wr_ctrl = psel && penable && pready && pwrite && paddr == RLS_OFS_CTRL;
  // Reserved codes select nothing
  always_comb begin
    case (sel_r)
      RLS_SRC_ALIGN: src = internal_alignment_pulse;
      RLS_SRC_LOOP0: src = first_loop_fb_div;
      RLS_SRC_D2:    src = digital_output_two;
      RLS_SRC_LOOP1: src = second_loop_fb_div;
      default:       src = 1'b0;
    endcase
  end
  // Mirrors settings so figures can be checked to within a few cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= RLS_SEL_RST;
      crl_r <= 1'b0;
      cnt_r <= {1'b0, RLS_COUNT_RST};
      src_r <= 8'h00;
      rel_r <= 8'h00;
      len_r <= 22'h000000;
    end else begin
      if (wr_ctrl) begin
        sel_r <= pwdata[3:0];
        crl_r <= pwdata[RLS_CTRL_CRL_BIT];
      end
      if (psel && penable && pready && pwrite && paddr == RLS_OFS_COUNT) begin
        cnt_r <= (pwdata[20:0] == 21'h0) ? 22'h000001 : {1'b0, pwdata[20:0]};
      end
      src_r <= {src_r[6:0], src};
      rel_r <= {rel_r[6:0], second_loop_fb_div};
      len_r <= rf_div_reset_hold ? len_r + 22'h000001 : 22'h000000;
    end
  end
  chk_pready_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("bus answer not after one wait");
  chk_slverr_map: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
    else $error("bus error flag wrong");
  chk_fb_choice: assert property (wr_ctrl |-> ##2 rf_feedback_clock_choice == $past(pwdata[4], 2))
    else $error("feedback choice not following control");
  chk_d2_gated: assert property (wr_ctrl && !pwdata[5] |-> ##2 !d2_trigger_clk[*2])
    else $error("trigger clock runs while disabled");
  chk_d2_follows: assert property (d2_trigger_clk |-> $past(digital_output_two, 3))
    else $error("trigger clock not from pin");
  chk_event_pulse: assert property (rf_sync_event |-> rf_div_reset_hold ##1 !rf_sync_event)
    else $error("sync event not one cycle with hold");
  chk_event_source: assert property (rf_sync_event |-> src_r[6:1] != 6'h00)
    else $error("sync event without chosen source");
  chk_hold_cause: assert property ($rose(rf_div_reset_hold) |-> rf_sync_event)
    else $error("hold rose without event");
  chk_loop_release: assert property ($fell(rf_div_reset_hold) && !crl_r |-> rel_r != 8'h00)
    else $error("hold released without loop edge");
  chk_count_release: assert property ($fell(rf_div_reset_hold) && crl_r |-> len_r >= cnt_r - 22'h1 && len_r <= cnt_r + 22'h2)
    else $error("hold length not the count");
endmodule
bind rls_top rls_top_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .internal_alignment_pulse(internal_alignment_pulse), .first_loop_fb_div(first_loop_fb_div),
  .second_loop_fb_div(second_loop_fb_div), .digital_output_two(digital_output_two),
  .rf_sync_event(rf_sync_event), .rf_div_reset_hold(rf_div_reset_hold),
  .rf_feedback_clock_choice(rf_feedback_clock_choice), .d2_trigger_clk(d2_trigger_clk));

// ===== test/rls_top_tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the sync source selector
module rls_top_tb_top
  import rls_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  pins = 4'h0;  // Source pins by vector index
  logic        ev;
  logic        hold;
  logic        fbc;
  logic        d2c;
  logic [31:0] rd;           // Last read data
  logic        rerr;         // Last error flag
  logic [3:0]  codes [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  int          err_total = 0;
  int          check_count = 0;
  int          seed = 32'h56CA89D7;
  int          ev_cnt = 0;   // Sync events seen
  int          e0;
  logic [31:0] v;
  always #25 pclk = ~pclk;
  // Counts events at the pin
  always @(posedge pclk) begin
    if (ev === 1'b1) ev_cnt <= ev_cnt + 1;
  end
  rls_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_alignment_pulse(pins[RLS_IDX_ALIGN]), .first_loop_fb_div(pins[RLS_IDX_LOOP0]),
    .second_loop_fb_div(pins[RLS_IDX_LOOP1]), .digital_output_two(pins[RLS_IDX_D2]),
    .rf_sync_event(ev), .rf_div_reset_hold(hold), .rf_feedback_clock_choice(fbc), .d2_trigger_clk(d2c));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Control word as read back while idle: defined fields only, go reads zero
  function automatic logic [31:0] ctrl_word(input logic [31:0] w);
    logic [31:0] m;
    m = 32'h0;
    m[RLS_CTRL_SEL_LSB +: RLS_CTRL_SEL_W] = 4'hF;
    m[RLS_CTRL_FBA_BIT] = 1'b1;
    m[RLS_CTRL_D2E_BIT] = 1'b1;
    m[RLS_CTRL_CRL_BIT] = 1'b1;
    return w & m;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One bus transfer; waits for the answer, then idles a cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    rerr = pslverr;
    if (pready !== 1'b1) begin
      err_total++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Pulses long enough for the edge detector
  task automatic pulse(input int i);
    pins[i] <= 1'b1;
    repeat (3) @(posedge pclk);
    pins[i] <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  // Polls status until not busy, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, RLS_OFS_STATUS, 32'h0);
      n++;
    end while (rd[RLS_STAT_BUSY] !== 1'b0 && n < 50);
    if (rd[RLS_STAT_BUSY] !== 1'b0) begin
      err_total++;
      conclude();
    end
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, RLS_OFS_CTRL, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, RLS_OFS_COUNT, 32'h0);
    check(rd, 32'h100000);
    apb(1'b0, 8'h0C, 32'h0);
    check({rd[30:0], rerr}, 32'h1);
    v = $random(seed) & 32'h1FFFFF;
    apb(1'b1, RLS_OFS_COUNT, v);
    apb(1'b0, RLS_OFS_COUNT, 32'h0);
    check(rd, v);
    // Feedback choice and trigger gating; the readback gives the choice time to settle
    apb(1'b1, RLS_OFS_CTRL, 32'h3F);
    apb(1'b0, RLS_OFS_CTRL, 32'h0);
    check(rd, ctrl_word(32'h3F));
    check(fbc, 1'b1);
    pins[RLS_IDX_D2] <= 1'b1;
    repeat (5) @(posedge pclk);
    check(d2c, 1'b1);
    apb(1'b1, RLS_OFS_CTRL, 32'h01);
    // Both outputs are registered once more after the write lands
    @(posedge pclk);
    check({fbc, d2c}, 2'b00);
    pins[RLS_IDX_D2] <= 1'b0;
    // Each source code, releases alternating between loop and count
    for (int k = 0; k < 4; k++) begin
      v = (k == 1) ? 32'h0 : 32'h2 + ($random(seed) & 32'h7);
      apb(1'b1, RLS_OFS_COUNT, v);
      apb(1'b1, RLS_OFS_CTRL, 32'h100 | (k[0] << 6) | codes[k]);
      e0 = ev_cnt;
      for (int i = 0; i < 4; i++) begin
        if (codes[k] != (4'h1 << i)) pulse(i);
      end
      check(ev_cnt, e0);
      for (int i = 0; i < 4; i++) begin
        if (codes[k] == (4'h1 << i)) pulse(i);
      end
      check(ev_cnt, e0 + 1);
      if (!k[0]) pulse(RLS_IDX_LOOP1);
      wait_idle();
      check(rd, 32'h2);
      apb(1'b1, RLS_OFS_STATUS, 32'h2);
    end
    // Reserved codes start nothing
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 32'h0 : 32'h3 + 32'hC * k;
      apb(1'b1, RLS_OFS_CTRL, 32'h100 | v);
      e0 = ev_cnt;
      for (int i = 0; i < 4; i++) pulse(i);
      apb(1'b0, RLS_OFS_STATUS, 32'h0);
      check(rd, 32'h0);
      check(ev_cnt, e0);
    end
    conclude();
  end
endmodule
